// >>> hw/timer2_config_control.sv
// second timer: configuration register, clock select, counter and reload
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
// Functional notes
// - step bit picks 65536 or one source clock
// - clock select picks crystal or slow rc
// - reload bit picks whether counting goes on after the reload, which happens in both modes
// - run enable write starts or stops counting
// - manual mode clears run enable on completion
module timer2_config_control #(
   parameter int STEP_DIV = timer2_pkg::LONG_STEP
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   input  wire logic        lowSpeedRcClock,
   input  wire logic        crystalClock,
   output logic             countDone,
   output logic             timerRunning
);
   localparam int TW   = timer2_pkg::TIMER_WIDTH;
   localparam int AW   = 8;
   localparam int DW   = 32;
   localparam int NSRC = 2;

   // hazards a user of this block should know:
   // - a config write in the completion cycle beats the hardware clear
   // - changing the source select may drop or add one tick at the switch
   // - the count is an up counter; completion is the step taken at all ones
   // - the status flag clears on read, but a completion in that cycle keeps it
   // - in long-step mode the prescaler restarts each time run is raised

   // register state and next values
   logic [7:0]      cfg_r;
   logic [7:0]      cfg_nxt;
   logic [TW-1:0]   count_r;
   logic [TW-1:0]   count_nxt;
   logic [TW-1:0]   reload_r;
   logic [TW-1:0]   reload_nxt;
   logic            done_r;
   logic            done_nxt;
   logic            doneSticky_r;
   logic            doneSticky_nxt;
   logic [DW-1:0]   rdata_r;
   logic [DW-1:0]   rdata_nxt;

   // synchronised source edges
   logic [NSRC-1:0] srcPin;
   logic [NSRC-1:0] srcRise;
   logic [NSRC-1:0] srcGated;
   logic            selRise;

   // configuration fields
   logic            runBit;
   logic            autoReload;
   logic            xtalSel;
   logic            longStep;
   logic [7:0]      cfgWrVal;

   // bus decode
   logic            hitCfg;
   logic            hitCount;
   logic            hitReload;
   logic            hitStatus;
   logic            wrCfg;
   logic            wrCount;
   logic            wrReload;
   logic            rdStatus;

   // counter events
   logic            step;
   logic            atTop;
   logic            complete;
   logic            hwClear;
   logic            doneSet;
   logic            doneClr;
   logic [TW-1:0]   countInc;

   // read words
   logic [DW-1:0]   cfgWord;
   logic [DW-1:0]   countWord;
   logic [DW-1:0]   reloadWord;
   logic [DW-1:0]   statusWord;
   logic [DW-1:0]   rdMux;

   tick_if tk ();

   // register address match, shared by write and read decode
   function automatic logic addrHit(input logic [AW-1:0] addr, input logic [AW-1:0] target);
      return addr == target;
   endfunction

   // source pins in select order: index 0 slow rc, index 1 crystal
   assign srcPin[0] = lowSpeedRcClock;
   assign srcPin[1] = crystalClock;

   // one synchroniser per source; selection after the flops avoids glitches
   for (genvar s = 0; s < NSRC; s++) begin : gSrc
      src_sync uSync (
         .sys_clk (sys_clk),
         .sys_rst (sys_rst),
         .srcIn   (srcPin[s]),
         .srcRise (srcRise[s])
      );
      assign srcGated[s] = srcRise[s] & (xtalSel == 1'(s));
   end

   // configuration fields as named wires
   assign runBit     = cfg_r[timer2_pkg::RUN_BIT];
   assign autoReload = cfg_r[timer2_pkg::RELOAD_BIT];
   assign xtalSel    = cfg_r[timer2_pkg::CLKSEL_BIT];
   assign longStep   = cfg_r[timer2_pkg::STEP_BIT];

   // only the selected source can produce a tick
   assign selRise = |srcGated;

   // prescaler controls; it restarts whenever run drops
   assign tk.srcTick  = selRise;
   assign tk.longStep = longStep;
   assign tk.run      = runBit;
   assign step        = tk.stepTick;

   step_prescaler #(.STEP_DIV(STEP_DIV)) uPre (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .tk      (tk)
   );

   // address decode
   assign hitCfg    = addrHit(regAddr, timer2_pkg::CFG_ADDR);
   assign hitCount  = addrHit(regAddr, timer2_pkg::COUNT_ADDR);
   assign hitReload = addrHit(regAddr, timer2_pkg::RELOAD_ADDR);
   assign hitStatus = addrHit(regAddr, timer2_pkg::STATUS_ADDR);

   // strobe qualification; unmapped addresses do nothing
   assign wrCfg    = regWr & hitCfg;
   assign wrCount  = regWr & hitCount;
   assign wrReload = regWr & hitReload;
   assign rdStatus = regRd & hitStatus;

   // count completes when a step lands on all ones
   assign atTop    = &count_r;
   assign complete = step & atTop;
   assign hwClear  = complete & ~autoReload;
   assign countInc = count_r + 1'b1;

   // writable config bits only; the rest read as zero
   assign cfgWrVal = regWdata[7:0] & timer2_pkg::CFG_WMASK;

   // config next value; a software write beats the hardware clear
   always_comb begin
      cfg_nxt = cfg_r;
      if (hwClear) begin
         cfg_nxt[timer2_pkg::RUN_BIT] = 1'b0;
      end
      if (wrCfg) begin
         cfg_nxt = cfgWrVal;
      end
   end

   // counter next value: reload on completion in either mode
   always_comb begin
      count_nxt = count_r;
      if (wrCount) begin
         count_nxt = regWdata[TW-1:0];
      end else if (complete) begin
         count_nxt = reload_r;
      end else if (step) begin
         count_nxt = countInc;
      end
   end

   // reload value changes only by software
   always_comb begin
      reload_nxt = reload_r;
      if (wrReload) begin
         reload_nxt = regWdata[TW-1:0];
      end
   end

   // done pulse follows completion by one cycle
   assign done_nxt = complete;

   // sticky done events
   assign doneSet = complete;
   assign doneClr = rdStatus;

   // sticky done: set wins over the clearing read
   always_comb begin
      doneSticky_nxt = doneSticky_r;
      if (doneClr) begin
         doneSticky_nxt = 1'b0;
      end
      if (doneSet) begin
         doneSticky_nxt = 1'b1;
      end
   end

   // read words, zero above each field
   assign cfgWord    = {24'h000000, cfg_r};
   assign countWord  = DW'(count_r);
   assign reloadWord = DW'(reload_r);
   assign statusWord = {31'h00000000, doneSticky_r};

   // read select; unmapped addresses read as zero
   assign rdMux = ({DW{hitCfg}}    & cfgWord)    |
                  ({DW{hitCount}}  & countWord)  |
                  ({DW{hitReload}} & reloadWord) |
                  ({DW{hitStatus}} & statusWord);

   // read data stand one cycle after the strobe, zero otherwise
   assign rdata_nxt = regRd ? rdMux : '0;

   // configuration register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_r <= timer2_pkg::CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // count register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   // reload register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reload_r <= '0;
      end else begin
         reload_r <= reload_nxt;
      end
   end

   // done pulse register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         done_r <= 1'b0;
      end else begin
         done_r <= done_nxt;
      end
   end

   // sticky done flag
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         doneSticky_r <= 1'b0;
      end else begin
         doneSticky_r <= doneSticky_nxt;
      end
   end

   // read data register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // outputs straight from flops
   assign regRdata     = rdata_r;
   assign countDone    = done_r;
   assign timerRunning = runBit;
endmodule // timer2_config_control

// >>> include/timer2_pkg.sv
// constants and types for the second timer control block
package timer2_pkg;
   // register map
   localparam logic [7:0] CFG_ADDR      = 8'h93;
   localparam logic [7:0] COUNT_ADDR    = 8'h94;
   localparam logic [7:0] RELOAD_ADDR   = 8'h98;
   localparam logic [7:0] STATUS_ADDR   = 8'h9c;
   // configuration field positions
   localparam int         RUN_BIT       = 0;
   localparam int         RELOAD_BIT    = 1;
   localparam int         CLKSEL_BIT    = 2;
   localparam int         STEP_BIT      = 3;
   localparam logic [7:0] CFG_RESET     = 8'h00;
   localparam logic [7:0] CFG_WMASK     = 8'h0f;
   // prescale step in long-step mode
   localparam int         LONG_STEP     = 65536;
   localparam int         TIMER_WIDTH   = 32;
   // prescaler state
   typedef enum logic [0:0] {
      PRE_IDLE = 1'b0,
      PRE_RUN  = 1'b1
   } pre_state_t;
endpackage

// >>> include/tick_if.sv
// source tick and step tick between prescaler and timer
`timescale 1ns/10ps
interface tick_if;
   logic srcTick;
   logic stepTick;
   logic longStep;
   logic run;
   modport pre (input srcTick, input longStep, input run, output stepTick);
   modport top (output srcTick, output longStep, output run, input stepTick);
endinterface

// >>> hw/src_sync.sv
// two-flop synchroniser and edge detector for one timer clock source
`timescale 1ns/10ps
module src_sync (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic srcIn,
   output logic      srcRise
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // two flops, then edge detect on the second only
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= srcIn;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign srcRise = sync_r & ~last_r;
endmodule // src_sync

// >>> hw/step_prescaler.sv
// prescaler: one step per source tick or per LONG_STEP ticks
`timescale 1ns/10ps
module step_prescaler #(
   parameter int STEP_DIV = timer2_pkg::LONG_STEP
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   tick_if.pre       tk
);
   localparam int CW = $clog2(STEP_DIV);
   logic [CW-1:0]          cnt_r;
   timer2_pkg::pre_state_t state_r;
   logic                   wrap;

   assign wrap = (cnt_r == CW'(STEP_DIV - 1));
   // long mode waits for a wrap, short mode passes each tick
   assign tk.stepTick = tk.srcTick & tk.run & (~tk.longStep | wrap);

   // count source ticks while running; restart when stopped
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r   <= '0;
         state_r <= timer2_pkg::PRE_IDLE;
      end else begin
         case (state_r)
            timer2_pkg::PRE_IDLE: begin
               cnt_r <= '0;
               // a tick in the cycle run rises still counts
               if (tk.run) begin
                  state_r <= timer2_pkg::PRE_RUN;
                  if (tk.srcTick) cnt_r <= wrap ? '0 : cnt_r + 1'b1;
               end
            end
            timer2_pkg::PRE_RUN: begin
               // enter idle with a clean count so a restart starts from zero
               if (!tk.run) begin
                  state_r <= timer2_pkg::PRE_IDLE;
                  cnt_r   <= '0;
               end else if (tk.srcTick) begin
                  cnt_r <= wrap ? '0 : cnt_r + 1'b1;
               end
            end
            default: state_r <= timer2_pkg::PRE_IDLE;
         endcase
      end
   end
endmodule // step_prescaler

// >>> bench/timer2_config_control_chk.sv
// port-level assertions for the second timer control block
`timescale 1ns/10ps
module timer2_config_control_chk #(
   parameter int STEP_DIV = timer2_pkg::LONG_STEP
) (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   input wire logic        lowSpeedRcClock,
   input wire logic        crystalClock,
   input wire logic        countDone,
   input wire logic        timerRunning
);
   logic [3:1] cfgShadow_r;
   wire        cfgWr = regWr && (regAddr == timer2_pkg::CFG_ADDR);
   // shadow of the bits only software changes
   always_ff @(posedge sys_clk or posedge sys_rst)
      if (sys_rst) cfgShadow_r <= 3'h0;
      else if (cfgWr) cfgShadow_r <= regWdata[3:1];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // config write, read back and completion behaviour
   AST_RUN_WRITE: assert property (cfgWr |=> timerRunning == $past(regWdata[0]))
      else $error("run bit not taken from write");
   AST_STOPPED: assert property (!timerRunning |=> !countDone)
      else $error("completion while stopped");
   AST_MANUAL_CLEAR: assert property (countDone && !cfgShadow_r[1] && !$past(cfgWr) |-> !timerRunning)
      else $error("manual mode kept running");
   AST_AUTO_KEEP: assert property (countDone && cfgShadow_r[1] && !$past(cfgWr) |-> timerRunning)
      else $error("auto mode stopped");
   AST_CFG_READ: assert property (regRd && regAddr == timer2_pkg::CFG_ADDR |=>
      regRdata == {28'h0, cfgShadow_r, $past(timerRunning)})
      else $error("config read wrong");
   AST_RDATA_IDLE: assert property (!regRd |=> regRdata == 32'h0)
      else $error("read data outside read slot");
   AST_DONE_PULSE: assert property (countDone |=> !countDone)
      else $error("done longer than one cycle");
   AST_RUN_HOLD: assert property (!cfgWr |=> countDone || $stable(timerRunning))
      else $error("run bit changed without cause");
endmodule // timer2_config_control_chk
bind timer2_config_control timer2_config_control_chk #(.STEP_DIV(STEP_DIV)) i_chk (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .lowSpeedRcClock(lowSpeedRcClock), .crystalClock(crystalClock),
   .countDone(countDone), .timerRunning(timerRunning));

// >>> bench/timer2_config_control_tb_top.sv
// self-checking bench for the second timer control block
`timescale 1ns/10ps
module timer2_config_control_tb_top;
   localparam int DIV = 4;
   logic        sys_clk = 0;
   logic        sys_rst = 1;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0, regRdata, x;
   logic        regWr = 0, regRd = 0, rcPin = 0, xtPin = 0, countDone, timerRunning;
   logic [31:0] seed = 32'h60562682;
   int          bad_count = 0, compares = 0, cyc = 0, n, doneSeen = 0, doneBase = 0;
   timer2_config_control #(.STEP_DIV(DIV)) i_timer2_config_control (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .lowSpeedRcClock(rcPin), .crystalClock(xtPin), .countDone(countDone), .timerRunning(timerRunning));
   // clock and hang guard
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (countDone === 1'b1) doneSeen++;
      if (cyc == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // steps expected from source ticks
   function automatic logic [31:0] expSteps(input logic step, input int ticks);
      return step ? 32'(ticks / DIV) : 32'(ticks);
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regWr <= 1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      regRd <= 1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 0;
      #1 chk(what, exp, regRdata);
   endtask
   // pulses on one source pin, slow enough for the synchroniser
   task automatic tick(input logic sel, input int k);
      repeat (k) begin
         @(posedge sys_clk);
         if (sel) xtPin <= 1;
         else rcPin <= 1;
         repeat (4) @(posedge sys_clk);
         rcPin <= 0;
         xtPin <= 0;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 0;
      rd_chk("cfg reset", timer2_pkg::CFG_ADDR, 32'h0);
      rd_chk("unmapped", 8'h00, 32'h0);
      for (int i = 0; i < 8; i++) begin
         x = xs() & 32'hffff_fffe;
         wr(timer2_pkg::CFG_ADDR, x);
         rd_chk("cfg", timer2_pkg::CFG_ADDR, x & 32'h0000_000f);
      end
      for (int m = 0; m < 4; m++) begin
         n = 2 * DIV + 1 + int'(xs() & 32'h3);
         wr(timer2_pkg::CFG_ADDR, 32'h0);
         wr(timer2_pkg::COUNT_ADDR, 32'h0);
         wr(timer2_pkg::CFG_ADDR, {28'h0, m[1], m[0], 2'b01});
         tick(!m[0], 3);
         tick(m[0], n);
         wr(timer2_pkg::CFG_ADDR, {28'h0, m[1], m[0], 2'b00});
         tick(m[0], 2);
         rd_chk("count", timer2_pkg::COUNT_ADDR, expSteps(m[1], n));
      end
      for (int r = 0; r < 2; r++) begin
         wr(timer2_pkg::CFG_ADDR, 32'h0);
         wr(timer2_pkg::RELOAD_ADDR, 32'h5);
         wr(timer2_pkg::COUNT_ADDR, 32'hffff_fffe);
         doneBase = doneSeen;
         wr(timer2_pkg::CFG_ADDR, {30'h0, r[0], 1'b1});
         tick(0, 2);
         #1 chk("running", 32'(r), {31'h0, timerRunning});
         chk("done pulses", 32'h1, 32'(doneSeen - doneBase));
         rd_chk("status set", timer2_pkg::STATUS_ADDR, 32'h1);
         rd_chk("status clear", timer2_pkg::STATUS_ADDR, 32'h0);
         tick(0, 1);
         rd_chk("reload", timer2_pkg::COUNT_ADDR, 32'h5 + 32'(r));
      end
      print_verdict();
   end
endmodule // timer2_config_control_tb_top
